// File: rtl/upf_pkg.sv
// constants for the paired endpoint buffer block
package upf_pkg;
  localparam logic [7:0] OFF_EP0_PORT  = 8'h00;
  localparam logic [7:0] OFF_EP1_PORT  = 8'h04;
  localparam logic [7:0] OFF_EP2_PORT  = 8'h08;
  localparam logic [7:0] OFF_EP3_PORT  = 8'h0c;
  localparam logic [7:0] OFF_EP3_MPS   = 8'h10;
  localparam logic [7:0] OFF_WAKEUP    = 8'h14;
  localparam logic [7:0] OFF_EP_CFG    = 8'h18;
  localparam logic [7:0] OFF_DMA_CTRL  = 8'h1c;
  localparam logic [7:0] OFF_PKT_READY = 8'h20;
  localparam logic [7:0] OFF_FILL      = 8'h24;
  localparam int CFG_DIR_BIT   = 7;
  localparam int CFG_KIND_LO   = 2;
  localparam int CFG_EP_STRIDE = 8;
  localparam int CFG_EP1_DIR   = 16;
  localparam int RDY_RX_LO     = 0;
  localparam int RDY_TX_LO     = 2;
  localparam int FILL_STRIDE   = 16;
  localparam int WK_REMOTE_WAKEUP_ENABLE_BIT   = 0;
  localparam int WK_OSC_BIT    = 1;
  localparam int WK_CAUSE_BIT  = 4;
  localparam logic [7:0] WAKEUP_RESET = 8'h10;
  localparam logic [15:0] MPS_RESET   = 16'h0000;
  localparam int PAIR_AW = 8;
  localparam logic [8:0] PAIR_DEPTH = 9'h100;
  localparam int SMALL_AW = 4;
  localparam logic [4:0] SMALL_DEPTH = 5'h10;
  typedef enum logic [1:0] {
    UPF_KIND_ISO  = 2'b01,
    UPF_KIND_BULK = 2'b10,
    UPF_KIND_INTR = 2'b11
  } upf_kind_t;
endpackage

// File: rtl/upf_top.sv
// endpoint buffer ports, paired ping-pong buffers and wake-up control
// What this block does
// R1: holds a 16-bit endpoint 3 receive maximum packet size, limit 0x100 (not enforced: any 16-bit value written is stored)
// R2: endpoint 0 port reads the receive buffer, writes fill the transmit buffer
// R3: endpoint 1 port read gives receive data only while receiving
// R4: endpoint 1 port write loads transmit data only while transmitting
// R5: endpoint 2 port reads and writes follow its direction
// R6: endpoint 3 port reads and writes follow its direction
// R7: width bit per endpoint 2/3: 0 byte access, 1 halfword access
// R8: wake-up control is 8 bits, read/write, resets to 0x10
// R9: wake-up bit 4 shows suspend (0) or wake-up (1) interrupt cause
// R10: oscillator handover bit gives USB side the clock in STOP mode
// R11: remote wake-up bit set by software, cleared after resume sent
// R12: unimplemented bits read as zero
// R13: endpoints 2/3 have two buffers, one on USB, one for CPU
// R14: bulk receive swaps on packet end when CPU buffer is empty
// R15: bulk receive NAKs further OUT data when both buffers hold data
// R16: clearing receive-ready with the other buffer full leaves it set
// R17: setting transmit-ready with one buffer loaded swaps, flag reads clear
// R18: bulk transmit also swaps when the host acknowledges the packet
// R19: isochronous transfers swap buffers on every start-of-frame
// R20: isochronous software needs no ready flag handling
// R21: isochronous software must finish buffer access before next frame start
// R22: direction bit per endpoint 2/3, 0 receive, resets to receive
// R23: transfer kind 01 iso, 10 bulk, 11 interrupt, resets to bulk
// R24: each paired buffer holds a full packet with its own count and ready
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module upf_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  usb_ep,
  input  wire logic        usb_wr_valid,
  input  wire logic [7:0]  usb_wr_data,
  input  wire logic        usb_pkt_done,
  input  wire logic        usb_rd_req,
  output logic      [7:0]  usb_rd_data,
  output logic      [8:0]  usb_tx_len,
  input  wire logic        usb_ack,
  input  wire logic        usb_sof,
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_resume_sent,
  input  wire logic        usb_suspend_evt,
  input  wire logic        usb_wake_evt,
  input  wire logic        stop_mode,
  output logic      [1:0]  usb_rx_nak,
  output logic      [1:0]  usb_tx_avail,
  output logic             osc_handover,
  output logic             remote_wakeup_en
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, upf_pkg::OFF_EP0_PORT) || hit(a, upf_pkg::OFF_EP1_PORT) ||
           hit(a, upf_pkg::OFF_EP2_PORT) || hit(a, upf_pkg::OFF_EP3_PORT) ||
           hit(a, upf_pkg::OFF_EP3_MPS) || hit(a, upf_pkg::OFF_WAKEUP) ||
           hit(a, upf_pkg::OFF_EP_CFG) || hit(a, upf_pkg::OFF_DMA_CTRL) ||
           hit(a, upf_pkg::OFF_PKT_READY) || hit(a, upf_pkg::OFF_FILL);
  endfunction

  logic                 pready_r;
  logic [31:0]          prdata_r;
  logic [31:0]          rd_mux;
  logic                 acc;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [15:0]          mps_r;
  logic                 remote_wakeup_enable_r;
  logic                 osc_r;
  logic                 cause_r;
  logic                 ep1_dir_r;
  logic                 ep_dir_r  [2];
  upf_pkg::upf_kind_t   ep_kind_r [2];
  logic                 dtw_r     [2];
  logic [15:0]          pair_rdata[2];
  logic [7:0]           pair_txb  [2];
  logic [8:0]           pair_txlen[2];
  logic [8:0]           pair_fill [2];
  logic                 pair_rxrdy[2];
  logic                 pair_txrdy[2];
  logic [7:0]           sm_head   [2][2];
  logic [4:0]           sm_cnt    [2][2];
  logic [7:0]           usb_rd_data_r;

  // one wait state so read data always comes from a flip-flop
  assign acc    = psel && penable && pready_r;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pready_r && !mapped(paddr);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mps_r <= upf_pkg::MPS_RESET;
    end else if (wr_acc && hit(paddr, upf_pkg::OFF_EP3_MPS)) begin
      mps_r <= pwdata[15:0]; // R1
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      remote_wakeup_enable_r  <= upf_pkg::WAKEUP_RESET[upf_pkg::WK_REMOTE_WAKEUP_ENABLE_BIT]; // R8
      osc_r   <= upf_pkg::WAKEUP_RESET[upf_pkg::WK_OSC_BIT];
      cause_r <= upf_pkg::WAKEUP_RESET[upf_pkg::WK_CAUSE_BIT];
    end else begin
      if (wr_acc && hit(paddr, upf_pkg::OFF_WAKEUP)) begin
        remote_wakeup_enable_r <= pwdata[upf_pkg::WK_REMOTE_WAKEUP_ENABLE_BIT];
        osc_r  <= pwdata[upf_pkg::WK_OSC_BIT];
      end
      // resume already went out, so a racing software set is stale
      if (usb_resume_sent) begin
        remote_wakeup_enable_r <= 1'b0; // R11
      end
      if (usb_wake_evt) begin
        cause_r <= 1'b1; // R9
      end else if (usb_suspend_evt) begin
        cause_r <= 1'b0; // R9
      end
    end
  end

  assign remote_wakeup_en = remote_wakeup_enable_r; // R11
  assign osc_handover = osc_r && stop_mode; // R10

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ep1_dir_r <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        ep_dir_r[i]  <= 1'b0;
        ep_kind_r[i] <= upf_pkg::UPF_KIND_BULK;
        dtw_r[i]     <= 1'b0;
      end
    end else if (usb_bus_reset) begin
      for (int i = 0; i < 2; i++) begin
        ep_dir_r[i]  <= 1'b0; // R22
        ep_kind_r[i] <= upf_pkg::UPF_KIND_BULK; // R23
      end
    end else begin
      if (wr_acc && hit(paddr, upf_pkg::OFF_EP_CFG)) begin
        ep1_dir_r <= pwdata[upf_pkg::CFG_EP1_DIR];
        for (int i = 0; i < 2; i++) begin
          ep_dir_r[i]  <= pwdata[upf_pkg::CFG_DIR_BIT + i * upf_pkg::CFG_EP_STRIDE]; // R22
          ep_kind_r[i] <= upf_pkg::upf_kind_t'(
            pwdata[upf_pkg::CFG_KIND_LO + i * upf_pkg::CFG_EP_STRIDE +: 2]); // R23
        end
      end
      if (wr_acc && hit(paddr, upf_pkg::OFF_DMA_CTRL)) begin
        for (int i = 0; i < 2; i++) begin
          dtw_r[i] <= pwdata[i]; // R7
        end
      end
    end
  end

  // endpoints 0 and 1: one receive and one transmit byte queue each
  genvar k;
  genvar d;
  generate
    for (k = 0; k < 2; k++) begin : g_small
      for (d = 0; d < 2; d++) begin : g_q
        logic [7:0]                  mem [upf_pkg::SMALL_DEPTH];
        logic [upf_pkg::SMALL_AW-1:0] wp_r;
        logic [upf_pkg::SMALL_AW-1:0] rp_r;
        logic [4:0]                  cnt_r;
        logic                        ok;
        logic                        port;
        logic                        push;
        logic                        pop;
        logic [7:0]                  din;
        // endpoint 0 always in both directions, endpoint 1 per its direction
        assign ok   = (k == 0) || (ep1_dir_r == (d == 1)); // R2 R3 R4
        assign port = hit(paddr, k == 0 ? upf_pkg::OFF_EP0_PORT : upf_pkg::OFF_EP1_PORT);
        assign push = ok && ((d == 0) ? (usb_wr_valid && usb_ep == 2'(k))
                                      : (wr_acc && port))
                      && cnt_r != upf_pkg::SMALL_DEPTH;
        assign pop  = ok && ((d == 0) ? (rd_acc && port)
                                      : (usb_rd_req && usb_ep == 2'(k)))
                      && cnt_r != 5'h00;
        assign din  = (d == 0) ? usb_wr_data : pwdata[7:0];
        assign sm_head[k][d] = mem[rp_r];
        assign sm_cnt[k][d]  = cnt_r;
        always_ff @(posedge core_clk) begin
          if (push) begin
            mem[wp_r] <= din;
          end
        end
        always_ff @(posedge core_clk or negedge resetn) begin
          if (!resetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= 5'h00;
          end else if (usb_bus_reset) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= 5'h00;
          end else begin
            if (push) begin
              wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
              rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + 5'(push) - 5'(pop);
          end
        end
      end
    end
  endgenerate

  // endpoints 2 and 3: two buffers, sel_r names the one facing USB
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair // R13
      logic [7:0]           mem [2][upf_pkg::PAIR_DEPTH]; // R24
      logic [8:0]           cnt_r [2];
      logic [8:0]           rdp_r [2];
      logic [1:0]           full_r;
      logic                 sel_r;
      logic                 cs;
      logic                 dir;
      logic                 iso;
      logic [8:0]           nb;
      logic                 usb_wr;
      logic                 usb_end;
      logic                 cpu_rd;
      logic                 cpu_wr;
      logic                 rx_clr;
      logic                 tx_set;
      logic                 usb_rdq;
      logic                 ack;
      logic                 sof;
      logic                 swap;
      logic [1:0]           full_nxt;
      logic [1:0]           free;
      logic                 port;
      assign cs   = !sel_r;
      assign dir  = ep_dir_r[p];
      assign iso  = ep_kind_r[p] == upf_pkg::UPF_KIND_ISO;
      assign nb   = dtw_r[p] ? 9'h002 : 9'h001; // R7
      assign port = hit(paddr, p == 0 ? upf_pkg::OFF_EP2_PORT : upf_pkg::OFF_EP3_PORT);
      assign usb_wr  = usb_wr_valid && usb_ep == 2'(p + 2) && !dir && !full_r[sel_r]
                       && cnt_r[sel_r] < upf_pkg::PAIR_DEPTH;
      assign usb_end = usb_pkt_done && usb_ep == 2'(p + 2) && !dir && !iso;
      assign cpu_rd  = rd_acc && port && !dir; // R5 R6
      assign cpu_wr  = wr_acc && port && dir
                       && cnt_r[cs] + nb <= upf_pkg::PAIR_DEPTH; // R5 R6
      assign rx_clr  = wr_acc && hit(paddr, upf_pkg::OFF_PKT_READY)
                       && pwdata[upf_pkg::RDY_RX_LO + p] && !dir && !iso;
      assign tx_set  = wr_acc && hit(paddr, upf_pkg::OFF_PKT_READY)
                       && pwdata[upf_pkg::RDY_TX_LO + p] && dir && !iso;
      assign usb_rdq = usb_rd_req && usb_ep == 2'(p + 2) && dir;
      assign ack     = usb_ack && usb_ep == 2'(p + 2) && dir && !iso;
      assign sof     = usb_sof && iso;

      always_comb begin
        full_nxt = full_r;
        free     = 2'b00;
        swap     = 1'b0;
        if (iso) begin
          // the buffer handed to the side that fills it starts empty
          full_nxt = 2'b00;
          swap     = sof; // R19
          if (sof) begin
            free[dir ? sel_r : cs] = 1'b1;
          end
        end else if (dir) begin
          if (tx_set && cnt_r[cs] != 9'h000) begin
            full_nxt[cs] = 1'b1;
          end
          if (ack) begin
            full_nxt[sel_r] = 1'b0;
            free[sel_r]     = 1'b1;
          end
          swap = full_nxt[cs] && !full_nxt[sel_r]; // R17 R18
        end else begin
          if (usb_end) begin
            full_nxt[sel_r] = 1'b1;
          end
          if (rx_clr) begin
            full_nxt[cs] = 1'b0;
            free[cs]     = 1'b1;
          end
          swap = full_nxt[sel_r] && !full_nxt[cs]; // R14 R16
        end
      end

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          full_r <= 2'b00;
          sel_r  <= 1'b0;
          for (int b = 0; b < 2; b++) begin
            cnt_r[b] <= 9'h000;
            rdp_r[b] <= 9'h000;
          end
        end else if (usb_bus_reset) begin
          full_r <= 2'b00;
          sel_r  <= 1'b0;
          for (int b = 0; b < 2; b++) begin
            cnt_r[b] <= 9'h000;
            rdp_r[b] <= 9'h000;
          end
        end else begin
          for (int b = 0; b < 2; b++) begin
            if (free[b]) begin
              cnt_r[b] <= 9'h000;
              rdp_r[b] <= 9'h000;
            end
          end
          if (usb_wr) begin
            cnt_r[sel_r] <= cnt_r[sel_r] + 9'h001;
          end
          if (cpu_wr) begin
            cnt_r[cs] <= cnt_r[cs] + nb;
          end
          if (cpu_rd) begin
            rdp_r[cs] <= rdp_r[cs] + nb;
          end
          if (usb_rdq) begin
            rdp_r[sel_r] <= rdp_r[sel_r] + 9'h001;
          end
          full_r <= full_nxt;
          if (swap) begin
            sel_r <= !sel_r;
          end
        end
      end

      // no reset on storage; the counts say what is valid
      always_ff @(posedge core_clk) begin
        if (usb_wr) begin
          mem[sel_r][cnt_r[sel_r][upf_pkg::PAIR_AW-1:0]] <= usb_wr_data;
        end
        if (cpu_wr) begin
          mem[cs][cnt_r[cs][upf_pkg::PAIR_AW-1:0]] <= pwdata[7:0];
          if (dtw_r[p]) begin
            mem[cs][cnt_r[cs][upf_pkg::PAIR_AW-1:0] + 1'b1] <= pwdata[15:8]; // R7
          end
        end
      end

      assign pair_rdata[p] = dir ? 16'h0000 :
        {dtw_r[p] ? mem[cs][rdp_r[cs][upf_pkg::PAIR_AW-1:0] + 1'b1] : 8'h00,
         mem[cs][rdp_r[cs][upf_pkg::PAIR_AW-1:0]]}; // R5 R6 R7
      assign pair_txb[p]   = mem[sel_r][rdp_r[sel_r][upf_pkg::PAIR_AW-1:0]];
      assign pair_txlen[p] = cnt_r[sel_r];
      assign pair_fill[p]  = cnt_r[cs];
      assign pair_rxrdy[p] = !dir && !iso && full_r[cs];
      assign pair_txrdy[p] = dir && !iso && full_r[cs];
      assign usb_rx_nak[p] = !dir && !iso && (&full_r); // R15
      assign usb_tx_avail[p] = dir && (iso || full_r[sel_r]);
    end
  endgenerate

  always_comb begin
    rd_mux = 32'h0000_0000; // R12
    case (paddr)
      upf_pkg::OFF_EP0_PORT: rd_mux[7:0] = sm_head[0][0]; // R2
      upf_pkg::OFF_EP1_PORT: rd_mux[7:0] = ep1_dir_r ? 8'h00 : sm_head[1][0]; // R3
      upf_pkg::OFF_EP2_PORT: rd_mux[15:0] = pair_rdata[0];
      upf_pkg::OFF_EP3_PORT: rd_mux[15:0] = pair_rdata[1];
      upf_pkg::OFF_EP3_MPS: rd_mux[15:0] = mps_r;
      upf_pkg::OFF_WAKEUP: begin
        rd_mux[upf_pkg::WK_REMOTE_WAKEUP_ENABLE_BIT]  = remote_wakeup_enable_r;
        rd_mux[upf_pkg::WK_OSC_BIT]   = osc_r;
        rd_mux[upf_pkg::WK_CAUSE_BIT] = cause_r;
      end
      upf_pkg::OFF_EP_CFG: begin
        rd_mux[upf_pkg::CFG_EP1_DIR] = ep1_dir_r;
        for (int i = 0; i < 2; i++) begin
          rd_mux[upf_pkg::CFG_DIR_BIT + i * upf_pkg::CFG_EP_STRIDE] = ep_dir_r[i];
          rd_mux[upf_pkg::CFG_KIND_LO + i * upf_pkg::CFG_EP_STRIDE +: 2] = ep_kind_r[i];
        end
      end
      upf_pkg::OFF_DMA_CTRL: rd_mux[1:0] = {dtw_r[1], dtw_r[0]};
      upf_pkg::OFF_PKT_READY: begin
        for (int i = 0; i < 2; i++) begin
          rd_mux[upf_pkg::RDY_RX_LO + i] = pair_rxrdy[i];
          rd_mux[upf_pkg::RDY_TX_LO + i] = pair_txrdy[i];
        end
      end
      upf_pkg::OFF_FILL: begin
        rd_mux[8:0] = pair_fill[0];
        rd_mux[upf_pkg::FILL_STRIDE +: 9] = pair_fill[1];
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      usb_rd_data_r <= 8'h00;
    end else if (usb_rd_req) begin
      case (usb_ep)
        2'h0: usb_rd_data_r <= sm_head[0][1];
        2'h1: usb_rd_data_r <= sm_head[1][1];
        2'h2: usb_rd_data_r <= pair_txb[0];
        default: usb_rd_data_r <= pair_txb[1];
      endcase
    end
  end
  assign usb_rd_data = usb_rd_data_r;

  always_comb begin
    case (usb_ep)
      2'h0: usb_tx_len = {4'h0, sm_cnt[0][1]};
      2'h1: usb_tx_len = {4'h0, sm_cnt[1][1]};
      2'h2: usb_tx_len = pair_txlen[0];
      default: usb_tx_len = pair_txlen[1];
    endcase
  end
endmodule
`default_nettype wire

// File: bench/upf_top_properties.sv
// port checker for the paired endpoint buffer block
`timescale 1ns/1ps
`default_nettype none
module upf_top_properties (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        usb_resume_sent,
  input wire logic        stop_mode,
  input wire logic        osc_handover,
  input wire logic        remote_wakeup_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic rd_done;
  logic wr_done;
  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;
  a_one_wait: assert property
    (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("wait state wrong");
  a_ready_pulse: assert property
    (pready |=> !pready) else $error("pready held");
  a_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h24))
    else $error("pslverr wrong");
  a_osc_stop: assert property
    (osc_handover |-> stop_mode) else $error("handover outside stop");
  a_osc_follow: assert property (wr_done && paddr == upf_pkg::OFF_WAKEUP
    |=> osc_handover == ($past(pwdata[1]) && stop_mode)) else $error("handover wrong");
  a_remote_wakeup_enable_set: assert property (wr_done && paddr == upf_pkg::OFF_WAKEUP
    && pwdata[0] && !usb_resume_sent |=> remote_wakeup_en) else $error("wake not set");
  a_remote_wakeup_enable_clear: assert property
    (usb_resume_sent |=> !remote_wakeup_en) else $error("wake not cleared");
  a_wake_zeros: assert property (rd_done && paddr == upf_pkg::OFF_WAKEUP
    |-> prdata[31:5] == 27'h0 && prdata[3:2] == 2'h0) else $error("wake spare set");
  a_mps_width: assert property (rd_done && paddr == upf_pkg::OFF_EP3_MPS
    |-> prdata[31:16] == 16'h0) else $error("size too wide");
  c_slverr: cover property (pready && pslverr);
  c_handover: cover property (osc_handover);
  c_remote_wakeup_enable: cover property (remote_wakeup_en ##1 !remote_wakeup_en);
endmodule
bind upf_top upf_top_properties i_upf_top_properties (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .usb_resume_sent(usb_resume_sent), .stop_mode(stop_mode), .osc_handover(osc_handover),
  .remote_wakeup_en(remote_wakeup_en));
`default_nettype wire

// File: bench/upf_host.sv
// behavioural usb host side for the paired endpoint buffer block
`timescale 1ns/1ps
`default_nettype none
module upf_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] usb_rd_data,
  output logic      [1:0] usb_ep,
  output logic            usb_wr_valid,
  output logic      [7:0] usb_wr_data,
  output logic            usb_rd_req,
  output logic      [6:0] evt
);
  initial begin
    usb_ep = 2'h0;
    usb_wr_valid = 1'b0;
    usb_wr_data = 8'h00;
    usb_rd_req = 1'b0;
    evt = 7'h00;
  end
  task automatic put(input logic [1:0] ep, input logic [7:0] d);
    @(posedge core_clk);
    usb_ep <= ep;
    usb_wr_valid <= 1'b1;
    usb_wr_data <= d;
    @(posedge core_clk);
    usb_wr_valid <= 1'b0;
    // released: show the inverse, not a stale byte
    usb_wr_data <= ~d;
  endtask
  // evt order: done, ack, sof, bus reset, resume sent, suspend, wake
  task automatic pulse(input logic [1:0] ep, input logic [6:0] m);
    @(posedge core_clk);
    usb_ep <= ep;
    evt <= m;
    @(posedge core_clk);
    evt <= 7'h00;
  endtask
  task automatic get(input logic [1:0] ep, output logic [7:0] d);
    @(posedge core_clk);
    usb_ep <= ep;
    usb_rd_req <= 1'b1;
    @(posedge core_clk);
    usb_rd_req <= 1'b0;
    @(negedge core_clk);
    d = usb_rd_data;
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the paired endpoint buffer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        stop_mode;
  logic [1:0]  usb_ep;
  logic        usb_wr_valid;
  logic [7:0]  usb_wr_data;
  logic        usb_rd_req;
  logic [6:0]  evt;
  logic [7:0]  usb_rd_data;
  logic [1:0]  usb_rx_nak;
  logic [1:0]  usb_tx_avail;
  logic [8:0]  usb_tx_len;
  logic        remote_wakeup_en;
  logic        osc_handover;
  logic [31:0] rdv;
  logic        errv;
  logic [7:0]  bv;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  upf_top i_upf_top (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_ep(usb_ep), .usb_wr_valid(usb_wr_valid), .usb_wr_data(usb_wr_data),
    .usb_pkt_done(evt[6]), .usb_rd_req(usb_rd_req), .usb_rd_data(usb_rd_data),
    .usb_tx_len(usb_tx_len), .usb_ack(evt[5]), .usb_sof(evt[4]), .usb_bus_reset(evt[3]),
    .usb_resume_sent(evt[2]), .usb_suspend_evt(evt[1]), .usb_wake_evt(evt[0]),
    .stop_mode(stop_mode), .usb_rx_nak(usb_rx_nak), .usb_tx_avail(usb_tx_avail),
    .osc_handover(osc_handover), .remote_wakeup_en(remote_wakeup_en));
  upf_host i_upf_host (
    .core_clk(core_clk), .usb_rd_data(usb_rd_data), .usb_ep(usb_ep),
    .usb_wr_valid(usb_wr_valid), .usb_wr_data(usb_wr_data), .usb_rd_req(usb_rd_req),
    .evt(evt));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // a hang ends here
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv & m, e);
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(upf_pkg::OFF_WAKEUP, '1, 32'h10, "wake reset");
    rdc(upf_pkg::OFF_EP_CFG, 32'h8c8c, 32'h0808, "cfg reset");
    wr(upf_pkg::OFF_EP3_MPS, 32'hffff0100);
    rdc(upf_pkg::OFF_EP3_MPS, '1, 32'h100, "max size");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", errv, 32'h1);
    $display("test registers done");
    wr(upf_pkg::OFF_WAKEUP, 32'hff);
    rdc(upf_pkg::OFF_WAKEUP, '1, 32'h13, "wake rw");
    @(posedge core_clk);
    stop_mode <= 1'b1;
    @(negedge core_clk);
    chk("handover", osc_handover, 32'h1);
    i_upf_host.pulse(2'h0, 7'b0000100);
    @(negedge core_clk);
    chk("remote wake", remote_wakeup_en, 32'h0);
    i_upf_host.pulse(2'h0, 7'b0000010);
    rdc(upf_pkg::OFF_WAKEUP, '1, 32'h02, "suspend cause");
    i_upf_host.pulse(2'h0, 7'b0000001);
    rdc(upf_pkg::OFF_WAKEUP, '1, 32'h12, "wake cause");
    $display("test wakeup done");
    i_upf_host.put(2'h0, 8'ha5);
    rdc(upf_pkg::OFF_EP0_PORT, 32'hff, 32'ha5, "ep0 rx");
    wr(upf_pkg::OFF_EP0_PORT, 32'h3c);
    i_upf_host.get(2'h0, bv);
    chk("ep0 tx", bv, 32'h3c);
    wr(upf_pkg::OFF_EP_CFG, 32'h0808);
    wr(upf_pkg::OFF_EP1_PORT, 32'h77);
    i_upf_host.put(2'h1, 8'h5a);
    rdc(upf_pkg::OFF_EP1_PORT, 32'hff, 32'h5a, "ep1 rx");
    wr(upf_pkg::OFF_EP_CFG, 32'h10808);
    wr(upf_pkg::OFF_EP1_PORT, 32'h66);
    i_upf_host.get(2'h1, bv);
    chk("ep1 tx", bv, 32'h66);
    $display("test single endpoints done");
    wr(upf_pkg::OFF_DMA_CTRL, 32'h1);
    for (int i = 1; i <= 4; i++) i_upf_host.put(2'h2, 8'(i));
    i_upf_host.pulse(2'h2, 7'b1000000);
    rdc(upf_pkg::OFF_PKT_READY, 32'h1, 32'h1, "ep2 ready");
    i_upf_host.put(2'h2, 8'h11);
    i_upf_host.put(2'h2, 8'h12);
    i_upf_host.pulse(2'h2, 7'b1000000);
    // both halves full: this byte must be refused
    i_upf_host.put(2'h2, 8'h99);
    @(negedge core_clk);
    chk("nak both", usb_rx_nak, 32'h1);
    rdc(upf_pkg::OFF_EP2_PORT, 32'hffff, 32'h0201, "ep2 half 0");
    rdc(upf_pkg::OFF_EP2_PORT, 32'hffff, 32'h0403, "ep2 half 1");
    wr(upf_pkg::OFF_PKT_READY, 32'h1);
    rdc(upf_pkg::OFF_PKT_READY, 32'h1, 32'h1, "ready kept");
    @(negedge core_clk);
    chk("nak gone", usb_rx_nak, 32'h0);
    rdc(upf_pkg::OFF_FILL, 32'h1ff, 32'h2, "fill");
    rdc(upf_pkg::OFF_EP2_PORT, 32'hffff, 32'h1211, "ep2 pkt b");
    wr(upf_pkg::OFF_PKT_READY, 32'h1);
    rdc(upf_pkg::OFF_PKT_READY, 32'h1, 32'h0, "ready clear");
    $display("test bulk receive done");
    wr(upf_pkg::OFF_EP_CFG, 32'h8808);
    wr(upf_pkg::OFF_EP3_PORT, 32'hab);
    wr(upf_pkg::OFF_EP3_PORT, 32'hcd);
    rdc(upf_pkg::OFF_EP3_PORT, '1, 32'h0, "ep3 tx read");
    wr(upf_pkg::OFF_PKT_READY, 32'h8);
    rdc(upf_pkg::OFF_PKT_READY, 32'h8, 32'h0, "tx swap");
    wr(upf_pkg::OFF_EP3_PORT, 32'hef);
    wr(upf_pkg::OFF_PKT_READY, 32'h8);
    rdc(upf_pkg::OFF_PKT_READY, 32'h8, 32'h8, "tx held");
    i_upf_host.get(2'h3, bv);
    chk("ep3 byte 0", bv, 32'hab);
    i_upf_host.get(2'h3, bv);
    chk("ep3 byte 1", bv, 32'hcd);
    chk("tx len", {usb_tx_avail, usb_tx_len}, 32'h402);
    i_upf_host.pulse(2'h3, 7'b0100000);
    rdc(upf_pkg::OFF_PKT_READY, 32'h8, 32'h0, "ack swap");
    i_upf_host.get(2'h3, bv);
    chk("ep3 pkt 2", bv, 32'hef);
    $display("test bulk transmit done");
    wr(upf_pkg::OFF_EP_CFG, 32'h0804);
    i_upf_host.put(2'h2, 8'h21);
    i_upf_host.put(2'h2, 8'h22);
    i_upf_host.pulse(2'h2, 7'b0010000);
    // no ready flag handling, read finished before the next frame start
    rdc(upf_pkg::OFF_EP2_PORT, 32'hffff, 32'h2221, "iso rx");
    i_upf_host.pulse(2'h0, 7'b0001000);
    rdc(upf_pkg::OFF_EP_CFG, 32'h8c8c, 32'h0808, "bus reset cfg");
    $display("test iso and bus reset done");
    close_out;
  end
endmodule
`default_nettype wire
